/* File: common/cmmbc_pkg.sv */
// constants and types shared by the minimum-mode bus control block
//
// Functional notes
// - rising urgent interrupt gives vector type 2
// - urgent interrupt has no mask
// - urgent interrupt taken at instruction end
// - urgent interrupt synchronised before edge detect
// - reset abandons current bus cycle at once
// - io_not_memory valid preceding T4 to final T4
// - hold acknowledge floats status, store and read strobes; irq ack strobe stays driven
// - store strobe low T2, T3, Tw of writes
// - irq ack strobe low T2, T3, Tw
// - address latch pulse in T1 low phase
// - address latch pulse never floated
// - xcvr_direction high transmit, timing as io_not_memory
// - read enable mid T2 to mid T4
// - write enable start T2 to mid T4
// - address in T1, data T2 to T4
// - read strobe low T2, T3, Tw of reads
package cmmbc_pkg;
    // timing: one bus T-state is three ref clocks, first one is the high phase
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROC_HIGH_PCT = 33;
    localparam int PHASES_PER_T = 100 / PROC_HIGH_PCT;
    localparam logic [1:0] PH_HIGH = 2'h0;
    localparam logic [1:0] PH_MID = 2'h1;
    localparam logic [1:0] PH_LAST = 2'h2;
    localparam int RST_MIN_CYCLES = 4;
    // vector type issued for an urgent interrupt
    localparam logic [7:0] URGENT_IRQ_TYPE = 8'h02;
    // bus cycle kinds
    localparam logic [2:0] KIND_MEM_RD = 3'h0;
    localparam logic [2:0] KIND_MEM_WR = 3'h1;
    localparam logic [2:0] KIND_IO_RD = 3'h2;
    localparam logic [2:0] KIND_IO_WR = 3'h3;
    localparam logic [2:0] KIND_IRQ_ACK_STROBE_N = 3'h4;
    localparam logic [2:0] KIND_RST = KIND_MEM_RD;
    typedef enum logic [2:0] {
        ST_TI = 3'h0,
        ST_T1 = 3'h1,
        ST_T2 = 3'h2,
        ST_T3 = 3'h3,
        ST_TW = 3'h4,
        ST_T4 = 3'h5,
        ST_TH = 3'h6
    } cmmbc_state_type;
endpackage

/* File: hw/cmmbc_sync2.sv */
// two-flop synchroniser for signals arriving from outside the clock domain
`timescale 1ns/1ps
module cmmbc_sync2 #(
    parameter int W = 1
) (
    input wire logic i_ref_clk, // clock
    input wire logic i_sys_rst, // sync reset, active high
    input wire logic [W-1:0] i_async, // raw pin level
    output logic [W-1:0] o_sync // synchronised level
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] sync_ff;
    logic [W-1:0] nxt_sync;

    // first stage feeds only the second stage
    always_comb begin
        nxt_meta = i_async;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign o_sync = sync_ff;
endmodule

/* File: hw/cmmbc_bus_ctrl.sv */
// minimum-mode bus sequencer, strobes, hold float and urgent interrupt logic
`timescale 1ns/1ps
module cmmbc_bus_ctrl (
    input wire logic i_ref_clk, // clock, 100 MHz
    input wire logic i_sys_rst, // sync reset, active high
    input wire logic i_bus_mode_select, // mode strap pin, high = minimum
    input wire logic i_urgent_interrupt_in, // urgent interrupt pin, async
    input wire logic i_ready, // ready pin from addressed device
    input wire logic i_hold_req, // bus hold request pin
    input wire logic [7:0] i_muxed_addr_data, // address/data pin input
    input wire logic i_cyc_req, // core bus request, held until ack
    input wire logic [2:0] i_cyc_kind, // core cycle kind
    input wire logic [7:0] i_cyc_addr, // core address
    input wire logic [7:0] i_cyc_wdata, // core write data
    input wire logic i_instr_end, // core pulse: instruction complete
    output logic o_cyc_ack, // request taken pulse
    output logic o_cyc_done, // cycle finished pulse
    output logic [7:0] o_cyc_rdata, // read data of last cycle
    output logic o_urgent_take, // urgent interrupt service pulse
    output logic [7:0] o_urgent_type, // vector type for service
    output logic o_core_run, // core may execute
    output logic o_min_mode, // synchronised strap
    output logic o_hold_ack, // hold acknowledge
    output logic o_addr_latch_pulse, // address latch pulse
    output logic o_io_not_memory, // io/memory status
    output logic o_io_not_memory_oe, // drive enable
    output logic o_store_strobe_n, // write strobe, active low
    output logic o_store_strobe_oe, // drive enable
    output logic o_read_strobe_n, // read strobe, active low
    output logic o_read_strobe_oe, // drive enable
    output logic o_irq_ack_strobe_n, // interrupt ack strobe, active low
    output logic o_irq_ack_strobe_oe, // drive enable
    output logic o_xcvr_direction, // transceiver direction, high = transmit
    output logic o_xcvr_direction_oe, // drive enable
    output logic o_xcvr_enable_n, // transceiver enable, active low
    output logic o_xcvr_enable_oe, // drive enable
    output logic [7:0] o_muxed_addr_data, // address/data pin output
    output logic o_muxed_addr_data_oe // address/data drive enable
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic urgent_s;
    logic ready_s;
    logic hold_s;
    logic mode_s;
    logic [7:0] ad_s;

    cmmbc_sync2 #(.W(1)) u_sync_urgent (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .i_async(i_urgent_interrupt_in), .o_sync(urgent_s));
    cmmbc_sync2 #(.W(1)) u_sync_ready (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .i_async(i_ready), .o_sync(ready_s));
    cmmbc_sync2 #(.W(1)) u_sync_hold (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .i_async(i_hold_req), .o_sync(hold_s));
    cmmbc_sync2 #(.W(1)) u_sync_mode (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .i_async(i_bus_mode_select), .o_sync(mode_s));
    cmmbc_sync2 #(.W(8)) u_sync_ad (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .i_async(i_muxed_addr_data), .o_sync(ad_s));

    // ----------------------------------------------------------------
    // urgent interrupt and run control
    // ----------------------------------------------------------------
    logic urg_dly_ff;
    logic nxt_urg_dly;
    logic urg_pend_ff;
    logic nxt_urg_pend;
    logic urg_take_ff;
    logic nxt_urg_take;
    logic run_ff;
    logic nxt_run;
    logic mode_ff;
    logic nxt_mode;

    // edge seen on the second sync stage; a new edge beats a same-cycle service
    always_comb begin
        nxt_urg_dly = urgent_s;
        nxt_urg_take = urg_pend_ff && i_instr_end && run_ff;
        nxt_urg_pend = urg_pend_ff;
        if (nxt_urg_take) begin
            nxt_urg_pend = 1'b0;
        end
        if (urgent_s && !urg_dly_ff) begin
            nxt_urg_pend = 1'b1;
        end
        nxt_run = 1'b1;
        nxt_mode = mode_s;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            urg_dly_ff <= 1'b0;
            urg_pend_ff <= 1'b0;
            urg_take_ff <= 1'b0;
            run_ff <= 1'b0;
            mode_ff <= 1'b0;
        end else begin
            urg_dly_ff <= nxt_urg_dly;
            urg_pend_ff <= nxt_urg_pend;
            urg_take_ff <= nxt_urg_take;
            run_ff <= nxt_run;
            mode_ff <= nxt_mode;
        end
    end

    assign o_urgent_take = urg_take_ff;
    assign o_urgent_type = cmmbc_pkg::URGENT_IRQ_TYPE;
    assign o_core_run = run_ff;
    assign o_min_mode = mode_ff;

    // ----------------------------------------------------------------
    // bus cycle sequencer
    // ----------------------------------------------------------------
    cmmbc_pkg::cmmbc_state_type state_ff;
    cmmbc_pkg::cmmbc_state_type nxt_state;
    logic [1:0] phase_ff;
    logic [1:0] nxt_phase;
    logic [2:0] cur_ff;
    logic [2:0] nxt_cur;
    logic [2:0] stat_ff;
    logic [2:0] nxt_stat;
    logic pend_ff;
    logic nxt_pend;
    logic [7:0] addr_ff;
    logic [7:0] nxt_addr;
    logic [7:0] wdata_ff;
    logic [7:0] nxt_wdata;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic ack_ff;
    logic nxt_ack;
    logic done_ff;
    logic nxt_done;
    logic last;
    logic take_req;

    // requests are taken in Ti or T4 so the status leads the cycle by a T4
    always_comb begin
        nxt_state = state_ff;
        nxt_cur = cur_ff;
        nxt_stat = stat_ff;
        nxt_pend = pend_ff;
        nxt_addr = addr_ff;
        nxt_wdata = wdata_ff;
        nxt_rdata = rdata_ff;
        nxt_ack = 1'b0;
        nxt_done = 1'b0;
        last = (phase_ff == cmmbc_pkg::PH_LAST);
        nxt_phase = last ? cmmbc_pkg::PH_HIGH : 2'(phase_ff + 2'h1);
        take_req = i_cyc_req && !ack_ff && !pend_ff && mode_ff && run_ff && !hold_s
            && (state_ff == cmmbc_pkg::ST_TI || state_ff == cmmbc_pkg::ST_T4);
        if (take_req) begin
            nxt_stat = i_cyc_kind;
            nxt_addr = i_cyc_addr;
            nxt_wdata = i_cyc_wdata;
            nxt_pend = 1'b1;
            nxt_ack = 1'b1;
        end
        unique case (state_ff)
            cmmbc_pkg::ST_TI: begin
                if (last && hold_s && !pend_ff) begin
                    nxt_state = cmmbc_pkg::ST_TH;
                end else if (last && pend_ff) begin
                    nxt_state = cmmbc_pkg::ST_T1;
                    nxt_cur = stat_ff;
                    nxt_pend = 1'b0;
                end
            end
            cmmbc_pkg::ST_T1: begin
                if (last) begin
                    nxt_state = cmmbc_pkg::ST_T2;
                end
            end
            cmmbc_pkg::ST_T2: begin
                if (last) begin
                    nxt_state = cmmbc_pkg::ST_T3;
                end
            end
            cmmbc_pkg::ST_T3, cmmbc_pkg::ST_TW: begin
                if (last) begin
                    // one wait state per T while ready stays low
                    nxt_state = ready_s ? cmmbc_pkg::ST_T4 : cmmbc_pkg::ST_TW;
                    if (ready_s) begin
                        nxt_rdata = ad_s;
                    end
                end
            end
            cmmbc_pkg::ST_T4: begin
                if (last) begin
                    nxt_done = 1'b1;
                    if (pend_ff || take_req) begin
                        nxt_state = cmmbc_pkg::ST_T1;
                        nxt_cur = take_req ? i_cyc_kind : stat_ff;
                        nxt_pend = 1'b0;
                    end else begin
                        nxt_state = hold_s ? cmmbc_pkg::ST_TH : cmmbc_pkg::ST_TI;
                    end
                end
            end
            cmmbc_pkg::ST_TH: begin
                if (last && !hold_s) begin
                    nxt_state = cmmbc_pkg::ST_TI;
                end
            end
            default: begin
                nxt_state = cmmbc_pkg::ST_TI;
            end
        endcase
    end

    // reset drops any cycle in flight immediately
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            state_ff <= cmmbc_pkg::ST_TI;
            phase_ff <= cmmbc_pkg::PH_HIGH;
            cur_ff <= cmmbc_pkg::KIND_RST;
            stat_ff <= cmmbc_pkg::KIND_RST;
            pend_ff <= 1'b0;
            addr_ff <= 8'h00;
            wdata_ff <= 8'h00;
            rdata_ff <= 8'h00;
            ack_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            phase_ff <= nxt_phase;
            cur_ff <= nxt_cur;
            stat_ff <= nxt_stat;
            pend_ff <= nxt_pend;
            addr_ff <= nxt_addr;
            wdata_ff <= nxt_wdata;
            rdata_ff <= nxt_rdata;
            ack_ff <= nxt_ack;
            done_ff <= nxt_done;
        end
    end

    assign o_cyc_ack = ack_ff;
    assign o_cyc_done = done_ff;
    assign o_cyc_rdata = rdata_ff;

    // ----------------------------------------------------------------
    // pin outputs, decoded from the next state so every pin is a flop
    // ----------------------------------------------------------------
    logic [15:0] pins_ff;
    logic [15:0] nxt_pins;
    logic [7:0] ad_ff;
    logic [7:0] nxt_ad;
    logic is_rd;
    logic is_wr;
    logic is_irq_ack_strobe_n;
    logic strobe_t;
    logic in_cyc;
    logic hold_n;

    always_comb begin
        is_wr = (nxt_cur == cmmbc_pkg::KIND_MEM_WR) || (nxt_cur == cmmbc_pkg::KIND_IO_WR);
        is_rd = (nxt_cur == cmmbc_pkg::KIND_MEM_RD) || (nxt_cur == cmmbc_pkg::KIND_IO_RD);
        is_irq_ack_strobe_n = (nxt_cur == cmmbc_pkg::KIND_IRQ_ACK_STROBE_N);
        strobe_t = (nxt_state == cmmbc_pkg::ST_T2) || (nxt_state == cmmbc_pkg::ST_T3)
            || (nxt_state == cmmbc_pkg::ST_TW);
        in_cyc = strobe_t || (nxt_state == cmmbc_pkg::ST_T4);
        hold_n = (nxt_state != cmmbc_pkg::ST_TH);
        nxt_pins = 16'h0000;
        nxt_pins[0] = (nxt_state == cmmbc_pkg::ST_TH);
        // latch pulse only in the low phases of T1, driven even in hold
        nxt_pins[1] = (nxt_state == cmmbc_pkg::ST_T1) && (nxt_phase != cmmbc_pkg::PH_HIGH);
        nxt_pins[2] = (nxt_stat == cmmbc_pkg::KIND_IO_RD) || (nxt_stat == cmmbc_pkg::KIND_IO_WR)
            || (nxt_stat == cmmbc_pkg::KIND_IRQ_ACK_STROBE_N);
        nxt_pins[3] = hold_n;
        nxt_pins[4] = !(strobe_t && is_wr);
        nxt_pins[5] = hold_n;
        nxt_pins[6] = !(strobe_t && is_rd);
        nxt_pins[7] = hold_n;
        nxt_pins[8] = !(strobe_t && is_irq_ack_strobe_n);
        nxt_pins[9] = 1'b1;
        nxt_pins[10] = (nxt_stat == cmmbc_pkg::KIND_MEM_WR) || (nxt_stat == cmmbc_pkg::KIND_IO_WR);
        nxt_pins[11] = hold_n;
        // write enable opens a third of a T earlier than read, both close mid T4
        if (is_wr) begin
            nxt_pins[12] = !(strobe_t || (nxt_state == cmmbc_pkg::ST_T4 && nxt_phase == cmmbc_pkg::PH_HIGH));
        end else begin
            nxt_pins[12] = !(((nxt_state == cmmbc_pkg::ST_T2) && (nxt_phase != cmmbc_pkg::PH_HIGH))
                || (nxt_state == cmmbc_pkg::ST_T3) || (nxt_state == cmmbc_pkg::ST_TW)
                || (nxt_state == cmmbc_pkg::ST_T4 && nxt_phase == cmmbc_pkg::PH_HIGH));
        end
        nxt_pins[13] = hold_n;
        // address in T1, write data after; lines float for ack cycles
        nxt_pins[14] = !is_irq_ack_strobe_n && ((nxt_state == cmmbc_pkg::ST_T1) || (in_cyc && is_wr));
        nxt_ad = (nxt_state == cmmbc_pkg::ST_T1) ? nxt_addr : nxt_wdata;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            pins_ff <= 16'h3bf8;
            ad_ff <= 8'h00;
        end else begin
            pins_ff <= nxt_pins;
            ad_ff <= nxt_ad;
        end
    end

    assign o_hold_ack = pins_ff[0];
    assign o_addr_latch_pulse = pins_ff[1];
    assign o_io_not_memory = pins_ff[2];
    assign o_io_not_memory_oe = pins_ff[3];
    assign o_store_strobe_n = pins_ff[4];
    assign o_store_strobe_oe = pins_ff[5];
    assign o_read_strobe_n = pins_ff[6];
    assign o_read_strobe_oe = pins_ff[7];
    assign o_irq_ack_strobe_n = pins_ff[8];
    assign o_irq_ack_strobe_oe = pins_ff[9];
    assign o_xcvr_direction = pins_ff[10];
    assign o_xcvr_direction_oe = pins_ff[11];
    assign o_xcvr_enable_n = pins_ff[12];
    assign o_xcvr_enable_oe = pins_ff[13];
    assign o_muxed_addr_data_oe = pins_ff[14];
    assign o_muxed_addr_data = ad_ff;
endmodule

/* File: bench/cmmbc_checker.sv */
// concurrent checks on the ports of the bus control block
`timescale 1ns/1ps
module cmmbc_checker (
    input wire logic i_ref_clk, // clock
    input wire logic i_sys_rst, // reset
    input wire logic i_instr_end, // core pulse
    input wire logic o_urgent_take, // service pulse
    input wire logic [7:0] o_urgent_type, // vector type
    input wire logic o_core_run, // core run
    input wire logic o_hold_ack, // hold ack
    input wire logic o_addr_latch_pulse, // latch pulse
    input wire logic o_io_not_memory, // io status
    input wire logic o_io_not_memory_oe, // enable
    input wire logic o_store_strobe_n, // write strobe
    input wire logic o_store_strobe_oe, // enable
    input wire logic o_read_strobe_n, // read strobe
    input wire logic o_read_strobe_oe, // enable
    input wire logic o_irq_ack_strobe_n, // ack strobe
    input wire logic o_xcvr_direction, // direction
    input wire logic o_xcvr_direction_oe, // enable
    input wire logic o_xcvr_enable_n, // xcvr enable
    input wire logic o_xcvr_enable_oe, // enable
    input wire logic o_muxed_addr_data_oe // bus enable
);
    // ----------------
    // strobe windows, hold float, urgent service and reset exit
    // ----------------
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);
    // enable must outlast the strobe by one clock, a third of a T-state
    sequence s_en_release;
        !o_xcvr_enable_n ##1 o_xcvr_enable_n;
    endsequence
    sequence s_ale_tail;
        o_addr_latch_pulse ##1 !o_addr_latch_pulse;
    endsequence
    property p_wr; !o_store_strobe_n |-> !o_xcvr_enable_n && o_xcvr_direction && o_read_strobe_n; endproperty
    a_wr: assert property (p_wr) else $error("store strobe outside transmit window");
    property p_rd; !o_read_strobe_n |-> !o_xcvr_direction && !o_muxed_addr_data_oe && o_store_strobe_n; endproperty
    a_rd: assert property (p_rd) else $error("read strobe while bus driven");
    property p_ack; !o_irq_ack_strobe_n |-> o_io_not_memory && !o_xcvr_direction && !o_muxed_addr_data_oe; endproperty
    a_ack: assert property (p_ack) else $error("ack strobe with wrong status");
    property p_wr_en; $fell(o_store_strobe_n) |-> $fell(o_xcvr_enable_n); endproperty
    a_wr_en: assert property (p_wr_en) else $error("write enable not at start of T2");
    property p_rd_en; $fell(o_read_strobe_n) || $fell(o_irq_ack_strobe_n) |-> o_xcvr_enable_n ##1 !o_xcvr_enable_n; endproperty
    a_rd_en: assert property (p_rd_en) else $error("read enable not mid T2");
    property p_en_end; $rose(o_read_strobe_n) || $rose(o_store_strobe_n) || $rose(o_irq_ack_strobe_n) |-> s_en_release; endproperty
    a_en_end: assert property (p_en_end) else $error("enable not released mid T4");
    property p_ale; $rose(o_addr_latch_pulse) |-> ##1 s_ale_tail; endproperty
    a_ale: assert property (p_ale) else $error("latch pulse width wrong");
    property p_float; o_hold_ack |-> !(o_io_not_memory_oe | o_store_strobe_oe | o_read_strobe_oe | o_xcvr_enable_oe); endproperty
    a_float: assert property (p_float) else $error("output driven in hold");
    property p_stat; !(o_read_strobe_n && o_store_strobe_n) |-> $stable(o_io_not_memory) && o_xcvr_direction_oe; endproperty
    a_stat: assert property (p_stat) else $error("status moved during strobe");
    property p_urg; o_urgent_take |-> $past(i_instr_end) && o_urgent_type == cmmbc_pkg::URGENT_IRQ_TYPE; endproperty
    a_urg: assert property (p_urg) else $error("urgent service wrong");
    property p_rst; $fell(i_sys_rst) |-> o_store_strobe_n && o_read_strobe_n && !o_core_run ##1 o_core_run; endproperty
    a_rst: assert property (p_rst) else $error("reset exit wrong");
endmodule

bind cmmbc_bus_ctrl cmmbc_checker chk_i (.i_ref_clk, .i_sys_rst, .i_instr_end, .o_urgent_take, .o_urgent_type,
    .o_core_run, .o_hold_ack, .o_addr_latch_pulse, .o_io_not_memory, .o_io_not_memory_oe, .o_store_strobe_n,
    .o_store_strobe_oe, .o_read_strobe_n, .o_read_strobe_oe, .o_irq_ack_strobe_n, .o_xcvr_direction,
    .o_xcvr_direction_oe, .o_xcvr_enable_n, .o_xcvr_enable_oe, .o_muxed_addr_data_oe);

/* File: bench/cmmbc_mem_model.sv */
// memory and io device model on the far side of the bus
`timescale 1ns/1ps
module cmmbc_mem_model #(
    parameter logic [7:0] VEC = 8'h4c // vector byte, value arbitrary
) (
    input wire logic i_ref_clk, // clock
    input wire logic i_ale, // latch pulse
    input wire logic i_rd_n, // read strobe
    input wire logic i_wr_n, // store strobe
    input wire logic i_ack_n, // ack strobe
    input wire logic i_io, // io status
    input wire logic [7:0] i_ad, // bus level
    input int i_waits, // wait states
    output logic [7:0] o_ad, // bus drive
    output logic o_ready // ready pin
);
    // ----------------
    // storage and answer
    // ----------------
    logic [7:0] mem [512];
    logic [8:0] adr = 9'h000;
    logic [7:0] last = 8'h00;
    logic drv;
    int cnt = 0;
    assign drv = !i_rd_n || !i_ack_n;
    // released bus shows the inverse of the last byte, never a stale copy
    assign o_ad = drv ? (i_ack_n ? mem[adr] : VEC) : ~last;
    // ready held back so that the block must insert the asked wait states
    assign o_ready = !(i_rd_n && i_wr_n && i_ack_n) && cnt >= (i_waits == 0 ? 0 : 3 * i_waits + 3);
    // address capture, write capture, strobe length count
    always @(posedge i_ref_clk) begin
        if (i_ale) adr <= {i_io, i_ad};
        if (!i_wr_n) mem[adr] <= i_ad;
        if (drv) last <= o_ad;
        cnt <= (i_rd_n && i_wr_n && i_ack_n) ? 0 : cnt + 1;
    end
endmodule

/* File: bench/tb_cpu_min_mode_bus_control.sv */
// self-checking bench for the minimum-mode bus control block
`timescale 1ns/1ps
module tb_cpu_min_mode_bus_control;
    localparam logic [7:0] MODEL_VEC = 8'h4c; // arbitrary vector byte
    logic i_ref_clk = 0, i_sys_rst = 1, i_bus_mode_select = 1, i_urgent_interrupt_in = 0, i_ready, i_hold_req = 0;
    logic i_cyc_req = 0, i_instr_end = 0, o_cyc_ack, o_cyc_done, o_urgent_take, o_core_run, o_min_mode, o_hold_ack;
    logic [7:0] i_muxed_addr_data, i_cyc_addr = 8'h00, i_cyc_wdata = 8'h00, o_cyc_rdata, o_urgent_type;
    logic [7:0] o_muxed_addr_data, mdl_ad;
    logic [2:0] i_cyc_kind = 3'h0;
    logic o_addr_latch_pulse, o_io_not_memory, o_io_not_memory_oe, o_store_strobe_n, o_store_strobe_oe;
    logic o_read_strobe_n, o_read_strobe_oe, o_irq_ack_strobe_n, o_irq_ack_strobe_oe, o_xcvr_direction;
    logic o_xcvr_direction_oe, o_xcvr_enable_n, o_xcvr_enable_oe, o_muxed_addr_data_oe;
    int fails = 0, comparisons = 0, waits = 0, cyc = 0;
    // ----------------
    // block, model, shared bus wire
    // ----------------
    assign i_muxed_addr_data = o_muxed_addr_data_oe ? o_muxed_addr_data : mdl_ad;
    cmmbc_bus_ctrl DUT (.i_ref_clk, .i_sys_rst, .i_bus_mode_select, .i_urgent_interrupt_in, .i_ready, .i_hold_req,
        .i_muxed_addr_data, .i_cyc_req, .i_cyc_kind, .i_cyc_addr, .i_cyc_wdata, .i_instr_end, .o_cyc_ack,
        .o_cyc_done, .o_cyc_rdata, .o_urgent_take, .o_urgent_type, .o_core_run, .o_min_mode, .o_hold_ack,
        .o_addr_latch_pulse, .o_io_not_memory, .o_io_not_memory_oe, .o_store_strobe_n, .o_store_strobe_oe,
        .o_read_strobe_n, .o_read_strobe_oe, .o_irq_ack_strobe_n, .o_irq_ack_strobe_oe, .o_xcvr_direction,
        .o_xcvr_direction_oe, .o_xcvr_enable_n, .o_xcvr_enable_oe, .o_muxed_addr_data, .o_muxed_addr_data_oe);
    cmmbc_mem_model #(.VEC(MODEL_VEC)) mdl (.i_ref_clk, .i_ale(o_addr_latch_pulse), .i_rd_n(o_read_strobe_n),
        .i_wr_n(o_store_strobe_n), .i_ack_n(o_irq_ack_strobe_n), .i_io(o_io_not_memory), .i_ad(i_muxed_addr_data),
        .i_waits(waits), .o_ad(mdl_ad), .o_ready(i_ready));
    // plain 50/50 clock; the block builds its own high phase inside each T-state
    initial begin
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    // hang guard: the whole run needs well under a thousand clocks
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 4000) begin
            fails++;
            $display("unexpected at %0t: run too long", $time);
            end_of_test;
        end
    end
    task automatic tick;
        @(posedge i_ref_clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // one whole bus cycle, judged on strobe lengths, status and latched address
    task automatic bus(input logic [2:0] k, input logic [7:0] a, input logic [7:0] d, input int w, output logic [7:0] q);
        int n = 0, lo = 0, tot = 0, al = 0;
        logic [7:0] aa;
        logic io, dir, s;
        aa = 8'h00;
        waits = w;
        i_cyc_kind = k;
        i_cyc_addr = a;
        i_cyc_wdata = d;
        i_cyc_req = 1;
        while (o_cyc_ack !== 1'b1 && n < 60) begin
            tick;
            n++;
        end
        i_cyc_req = 0;
        while (o_cyc_done !== 1'b1 && n < 200) begin
            tick;
            n++;
            s = (k == cmmbc_pkg::KIND_IRQ_ACK_STROBE_N) ? o_irq_ack_strobe_n : (k[0] ? o_store_strobe_n : o_read_strobe_n);
            lo += int'(!s);
            tot += int'(!o_read_strobe_n) + int'(!o_store_strobe_n) + int'(!o_irq_ack_strobe_n);
            if (o_addr_latch_pulse === 1'b1) begin
                al++;
                aa = o_muxed_addr_data;
                io = o_io_not_memory;
                dir = o_xcvr_direction;
            end
        end
        chk({7'h00, o_cyc_done}, 8'h01, "cycle done");
        chk(8'(al), 8'h02, "latch pulse clocks");
        chk(8'(lo), 8'(6 + 3 * w), "strobe low clocks");
        chk(8'(tot), 8'(lo), "foreign strobe");
        chk({7'h00, io}, {7'h00, k inside {cmmbc_pkg::KIND_IO_RD, cmmbc_pkg::KIND_IO_WR, cmmbc_pkg::KIND_IRQ_ACK_STROBE_N}}, "io");
        chk({7'h00, dir}, {7'h00, k inside {cmmbc_pkg::KIND_MEM_WR, cmmbc_pkg::KIND_IO_WR}}, "direction");
        if (k != cmmbc_pkg::KIND_IRQ_ACK_STROBE_N) chk(aa, a, "latched address");
        q = o_cyc_rdata;
    endtask
    task automatic t_kinds;
        logic [7:0] q;
        bus(cmmbc_pkg::KIND_MEM_WR, 8'h33, 8'h5a, 1, q);
        bus(cmmbc_pkg::KIND_IO_WR, 8'h33, 8'ha6, 2, q);
        bus(cmmbc_pkg::KIND_MEM_RD, 8'h33, 8'h00, 0, q);
        chk(q, 8'h5a, "memory read");
        bus(cmmbc_pkg::KIND_IO_RD, 8'h33, 8'h00, 1, q);
        chk(q, 8'ha6, "io read");
        bus(cmmbc_pkg::KIND_IRQ_ACK_STROBE_N, 8'h00, 8'h00, 2, q);
        chk(q, MODEL_VEC, "vector byte");
        $display("test kinds done");
    endtask
    task automatic t_hold;
        int n = 0;
        i_hold_req = 1;
        while (o_hold_ack !== 1'b1 && n < 40) begin
            tick;
            n++;
        end
        chk({o_io_not_memory_oe, o_store_strobe_oe, o_read_strobe_oe, o_xcvr_direction_oe, o_xcvr_enable_oe,
            o_addr_latch_pulse, o_muxed_addr_data_oe, o_hold_ack}, 8'h01, "floated in hold");
        i_hold_req = 0;
        while (o_hold_ack !== 1'b0 && n < 80) begin
            tick;
            n++;
        end
        chk({2'h0, o_irq_ack_strobe_oe, o_io_not_memory_oe, o_store_strobe_oe, o_read_strobe_oe, o_xcvr_direction_oe,
            o_xcvr_enable_oe}, 8'h3f, "driven after hold");
        $display("test hold done");
    endtask
    task automatic t_urgent;
        int n = 0;
        i_urgent_interrupt_in = 1;
        repeat (8) begin
            tick;
            if (o_urgent_take !== 1'b0) n++;
        end
        chk(8'(n), 8'h00, "service before instruction end");
        for (int p = 0; p < 2; p++) begin
            i_instr_end = 1;
            repeat (4) begin
                tick;
                i_instr_end = 0;
                if (o_urgent_take !== 1'b0) n++;
            end
        end
        chk(8'(n), 8'h01, "one service per rising edge");
        chk(o_urgent_type, 8'h02, "vector type");
        i_urgent_interrupt_in = 0;
        $display("test urgent done");
    endtask
    task automatic t_strap;
        int n = 0;
        logic [7:0] q;
        i_bus_mode_select = 0;
        repeat (4) tick;
        i_cyc_req = 1;
        repeat (20) begin
            tick;
            if (o_cyc_ack !== 1'b0) n++;
        end
        chk({7'h00, o_min_mode}, 8'h00, "strap low seen");
        chk(8'(n), 8'h00, "no cycle with strap low");
        i_bus_mode_select = 1;
        bus(cmmbc_pkg::KIND_MEM_RD, 8'h33, 8'h00, 0, q);
        chk(q, 8'h5a, "read after strap high");
        $display("test strap done");
    endtask
    task automatic t_reset;
        int n;
        n = 0;
        i_cyc_kind = cmmbc_pkg::KIND_MEM_WR;
        i_cyc_req = 1;
        while (o_store_strobe_n !== 1'b0 && n < 60) begin
            tick;
            n++;
            if (o_cyc_ack === 1'b1) i_cyc_req = 0;
        end
        i_sys_rst = 1;
        tick;
        chk({5'h00, o_store_strobe_n, o_xcvr_enable_n, o_core_run}, 8'h06, "cycle abandoned");
        repeat (3) tick; // four clocks in reset
        i_sys_rst = 0;
        tick;
        chk({7'h00, o_core_run}, 8'h01, "run after release");
        tick;
        $display("test reset done");
    endtask
    task automatic end_of_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (4) tick;
        i_sys_rst = 0;
        tick;
        t_kinds;
        t_hold;
        t_urgent;
        t_strap;
        t_reset;
        end_of_test;
    end
endmodule
